// ### rtl/mcrd_pkg.sv
// Package: shared constants for the code-read DMA control block.
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package mcrd_pkg;
   // Register byte offsets.
   localparam logic [7:0] ADDR_BASE = 8'h30;
   localparam logic [7:0] ADDR_CTRL = 8'h34;
   localparam logic [7:0] ADDR_PTR = 8'h38;
   localparam logic [7:0] ADDR_STAT = 8'h3C;
   // Control and status register fields.
   localparam int B_TIMEOUT = 30;
   localparam int B_EMPTY = 29;
   localparam int B_FLUSH = 28;
   localparam int F_GUEST_LO = 20;
   localparam int F_GREG_LO = 16;
   localparam int F_SIZE_LO = 12;
   localparam int F_STEP_LO = 8;
   localparam int B_RDEN = 7;
   localparam int F_THR_LO = 1;
   localparam int B_AUTO = 0;
   localparam int B_REPIRQ = 28;
   // Reset values.
   localparam logic [2:0] SIZE_RST = 3'h3;
   localparam logic [2:0] STEP_RST = 3'h1;
   localparam logic [2:0] THR_RST = 3'h6;
   localparam logic [29:0] BASE_RST = 30'h3FFFFFFF;
   // 8 kbyte is 2048 DWORDs, so codes 0 to 5 scale as 2^(11+code); codes 6 and 7 read as code 3.
   localparam int DW_8K_LOG2 = 11;
   localparam int TIMEOUT_CLKS = 64;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      GW_IDLE = 2'b00,
      GW_WAIT = 2'b01,
      GW_DONE = 2'b10
   } mcrd_gw_t;
endpackage

// ### rtl/mcrd_fifo.sv
// Code FIFO holding DWORDs between host reads and guest writes.
`timescale 1ns/1ps
`default_nettype none
module mcrd_fifo #(
   parameter int DEPTH_LOG2 = 3
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   input wire logic flush,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [31:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [31:0] out_data,
   output logic [DEPTH_LOG2:0] level
);
   logic [31:0] mem [2**DEPTH_LOG2];
   logic [DEPTH_LOG2:0] wr_ff;
   logic [DEPTH_LOG2:0] rd_ff;
   logic push;
   logic pop;

   assign level = wr_ff - rd_ff;
   assign in_ready = !flush && (level != (DEPTH_LOG2+1)'(1 << DEPTH_LOG2));
   assign out_valid = !flush && (level != '0);
   assign out_data = mem[rd_ff[DEPTH_LOG2-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // While flushed, the pointers are held equal so contents are lost.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else if (flush) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (pop) begin
            rd_ff <= rd_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ff[DEPTH_LOG2-1:0]] <= in_data;
      end
   end
endmodule // mcrd_fifo
`default_nettype wire

// ### rtl/mcrd_guest_wr.sv
// Guest-bus code-write cycle engine with timeout detection.
`timescale 1ns/1ps
`default_nettype none
module mcrd_guest_wr #(
   parameter int TIMEOUT = 64
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Word from the FIFO.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [31:0] in_data,
   // Guest bus.
   output logic gw_req,
   output logic [31:0] gw_data,
   input wire logic gw_done,
   // One-cycle pulse when a write cycle overruns.
   output logic timeout_pulse
);
   mcrd_pkg::mcrd_gw_t state_ff;
   logic [7:0] cnt_ff;

   assign in_ready = (state_ff == mcrd_pkg::GW_IDLE);
   assign gw_req = (state_ff == mcrd_pkg::GW_WAIT);
   assign timeout_pulse = gw_req && !gw_done && (cnt_ff == 8'(TIMEOUT));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= mcrd_pkg::GW_IDLE;
         cnt_ff <= 8'h00;
         gw_data <= 32'h0;
      end else begin
         case (state_ff)
            mcrd_pkg::GW_IDLE: begin
               cnt_ff <= 8'h00;
               if (in_valid) begin
                  gw_data <= in_data;
                  state_ff <= mcrd_pkg::GW_WAIT;
               end
            end
            mcrd_pkg::GW_WAIT: begin
               // The counter saturates after the flag so one cycle reports once.
               if (cnt_ff <= 8'(TIMEOUT)) begin
                  cnt_ff <= cnt_ff + 8'h01;
               end
               if (gw_done) begin
                  state_ff <= mcrd_pkg::GW_DONE;
               end
            end
            mcrd_pkg::GW_DONE: begin
               state_ff <= mcrd_pkg::GW_IDLE;
            end
            default: begin
               state_ff <= mcrd_pkg::GW_IDLE;
            end
         endcase
      end
   end
endmodule // mcrd_guest_wr
`default_nettype wire

// ### rtl/mcrd_ctrl.sv
// Code-read DMA control: registers, host read requests, FIFO and guest writes.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mcrd_ctrl #(
   parameter int FIFO_LOG2 = 3
) (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST,
   // AXI4-Lite write address and data.
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [7:0] AWADDR,
   input wire logic WVALID,
   output logic WREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   // AXI4-Lite write response.
   output logic BVALID,
   input wire logic BREADY,
   output logic [1:0] BRESP,
   // AXI4-Lite read.
   input wire logic ARVALID,
   output logic ARREADY,
   input wire logic [7:0] ARADDR,
   output logic RVALID,
   input wire logic RREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   // Host memory read port, one DWORD per handshake.
   output logic HOST_RD_REQ,
   output logic [31:0] HOST_RD_ADDR,
   input wire logic HOST_RD_VALID,
   input wire logic [31:0] HOST_RD_DATA,
   // Guest code-write port.
   output logic GUEST_WR_REQ,
   output logic [2:0] GUEST_SEL,
   output logic [2:0] GUEST_REG,
   output logic [31:0] GUEST_WR_DATA,
   input wire logic GUEST_WR_DONE
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [29:0] base_ff;
   logic [15:0] ptr_ff;
   logic timeout_ff;
   logic flush_ff;
   logic [2:0] guest_ff;
   logic [2:0] greg_ff;
   logic [2:0] size_ff;
   logic [2:0] step_ff;
   logic rden_ff;
   logic [2:0] thr_ff;
   logic auto_ff;
   logic repirq_ff;
   logic stopped_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic aw_ff;
   logic w_ff;
   logic [31:0] nxt_rdata;
   logic [1:0] nxt_rresp;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Buffer length in DWORDs for a size code.
   function automatic logic [17:0] size_dw(input logic [2:0] code);
      logic [2:0] c;
      c = (code > 3'h5) ? mcrd_pkg::SIZE_RST : code;
      return 18'(1) << (mcrd_pkg::DW_8K_LOG2 + int'(c));
   endfunction

   logic [17:0] buf_dw;
   logic [17:0] step_dw;
   logic [17:0] ptr_next;
   logic at_end;
   logic fifo_in_ready;
   logic fifo_empty;
   logic [FIFO_LOG2:0] fifo_level;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [31:0] fifo_out_data;
   logic timeout_pulse;
   logic wr_fire;
   logic ctrl_wr;
   logic clr_timeout;
   logic clr_rep;
   logic rep_pass;
   logic take;

   logic base_wr;
   logic ptr_wr;
   logic stat_wr;

   // One compare for every register strobe.
   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
      logic hit;
      hit = (addr == target);
      return hit;
   endfunction

   // 256 kbyte is 65536 DWORDs, so the end
   // test needs 17 bits.
   assign buf_dw = size_dw(size_ff);
   assign step_dw = size_dw(step_ff);
   assign ptr_next = {2'b00, ptr_ff} + 18'h1;
   assign at_end = (ptr_next >= buf_dw);
   // Empty follows the level, so it also
   // reads one once the guest drains.
   assign fifo_empty = (fifo_level == '0);

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   assign AWREADY = !aw_ff && !BVALID;
   assign WREADY = !w_ff && !BVALID;
   // One write and one read in flight;
   // the answer waits for both halves.
   assign ARREADY = !RVALID;
   assign wr_fire = aw_ff && w_ff && !BVALID;
   // Register strobes.
   assign ctrl_wr = wr_fire && reg_hit(awaddr_ff, mcrd_pkg::ADDR_CTRL);
   assign base_wr = wr_fire && reg_hit(awaddr_ff, mcrd_pkg::ADDR_BASE);
   assign ptr_wr = wr_fire && reg_hit(awaddr_ff, mcrd_pkg::ADDR_PTR);
   assign stat_wr = wr_fire && reg_hit(awaddr_ff, mcrd_pkg::ADDR_STAT);

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
         BVALID <= 1'b0;
         BRESP <= mcrd_pkg::RESP_OKAY;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_ff <= 1'b1;
            awaddr_ff <= {AWADDR[7:2], 2'b00};
         end
         if (WVALID && WREADY) begin
            w_ff <= 1'b1;
            wdata_ff <= WDATA;
            wstrb_ff <= WSTRB;
         end
         if (wr_fire) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            BVALID <= 1'b1;
            case (awaddr_ff)
               mcrd_pkg::ADDR_BASE, mcrd_pkg::ADDR_CTRL,
               mcrd_pkg::ADDR_PTR, mcrd_pkg::ADDR_STAT: BRESP <= mcrd_pkg::RESP_OKAY;
               default: BRESP <= mcrd_pkg::RESP_SLVERR;
            endcase
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // Decoded at the handshake and then held,
   // so later state changes leave it alone.
   always_comb begin
      nxt_rdata = 32'h0;
      nxt_rresp = mcrd_pkg::RESP_OKAY;
      case ({ARADDR[7:2], 2'b00})
         mcrd_pkg::ADDR_BASE: nxt_rdata = {base_ff, 2'b00};
         mcrd_pkg::ADDR_CTRL: begin
            nxt_rdata[mcrd_pkg::B_TIMEOUT] = timeout_ff;
            nxt_rdata[mcrd_pkg::B_EMPTY] = fifo_empty;
            nxt_rdata[mcrd_pkg::B_FLUSH] = flush_ff;
            nxt_rdata[mcrd_pkg::F_GUEST_LO +: 3] = guest_ff;
            nxt_rdata[mcrd_pkg::F_GREG_LO +: 3] = greg_ff;
            nxt_rdata[mcrd_pkg::F_SIZE_LO +: 3] = size_ff;
            nxt_rdata[mcrd_pkg::F_STEP_LO +: 3] = step_ff;
            nxt_rdata[mcrd_pkg::B_RDEN] = rden_ff;
            nxt_rdata[mcrd_pkg::F_THR_LO +: 3] = thr_ff;
            nxt_rdata[mcrd_pkg::B_AUTO] = auto_ff;
         end
         mcrd_pkg::ADDR_PTR: nxt_rdata[15:0] = ptr_ff;
         mcrd_pkg::ADDR_STAT: nxt_rdata[mcrd_pkg::B_REPIRQ] = repirq_ff;
         default: nxt_rresp = mcrd_pkg::RESP_SLVERR;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         RVALID <= 1'b0;
         RDATA <= 32'h0;
         RRESP <= mcrd_pkg::RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RDATA <= nxt_rdata;
         RRESP <= nxt_rresp;
      end else if (RVALID && RREADY) begin
         // Stands until taken.
         RVALID <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // Each control byte lane owns its fields, so a
   // partial write leaves the others alone; base writes ignore the strobes.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         flush_ff <= 1'b1;
         guest_ff <= 3'h0;
         greg_ff <= 3'h0;
         size_ff <= mcrd_pkg::SIZE_RST;
         step_ff <= mcrd_pkg::STEP_RST;
         rden_ff <= 1'b0;
         thr_ff <= mcrd_pkg::THR_RST;
         auto_ff <= 1'b0;
      end else if (ctrl_wr) begin
         if (wstrb_ff[3]) begin
            flush_ff <= wdata_ff[mcrd_pkg::B_FLUSH];
         end
         if (wstrb_ff[2]) begin
            guest_ff <= wdata_ff[mcrd_pkg::F_GUEST_LO +: 3];
            greg_ff <= wdata_ff[mcrd_pkg::F_GREG_LO +: 3];
         end
         if (wstrb_ff[1]) begin
            size_ff <= wdata_ff[mcrd_pkg::F_SIZE_LO +: 3];
            step_ff <= wdata_ff[mcrd_pkg::F_STEP_LO +: 3];
         end
         if (wstrb_ff[0]) begin
            rden_ff <= wdata_ff[mcrd_pkg::B_RDEN];
            thr_ff <= wdata_ff[mcrd_pkg::F_THR_LO +: 3];
            auto_ff <= wdata_ff[mcrd_pkg::B_AUTO];
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         base_ff <= mcrd_pkg::BASE_RST;
      end else if (base_wr) begin
         base_ff <= wdata_ff[31:2];
      end
   end

   // ----------------------------------------------------------------
   // Sticky flags
   // ----------------------------------------------------------------
   assign clr_timeout = ctrl_wr && wstrb_ff[3] && wdata_ff[mcrd_pkg::B_TIMEOUT];
   assign clr_rep = stat_wr && wstrb_ff[3] && wdata_ff[mcrd_pkg::B_REPIRQ];

   // Set is tested first: a timeout in the
   // cycle of a clearing write stays seen.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         timeout_ff <= 1'b0;
      end else if (timeout_pulse) begin
         timeout_ff <= 1'b1;
      end else if (clr_timeout) begin
         timeout_ff <= 1'b0;
      end
   end

   // Same priority for the report flag.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         repirq_ff <= 1'b0;
      end else if (rep_pass) begin
         repirq_ff <= 1'b1;
      end else if (clr_rep) begin
         repirq_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Code-read DMA
   // ----------------------------------------------------------------
   // The level threshold and in_ready keep the FIFO from overflowing under requests.
   assign HOST_RD_REQ = rden_ff && !stopped_ff && !flush_ff && fifo_in_ready
      && (fifo_level < (FIFO_LOG2+1)'(thr_ff));
   assign HOST_RD_ADDR = {base_ff + 30'(ptr_ff), 2'b00};
   // A stray valid without request is ignored.
   assign take = HOST_RD_VALID && HOST_RD_REQ;
   assign rep_pass = take && ((ptr_next & (step_dw - 18'h1)) == 18'h0);

   // Pointer writes count only while reading
   // is off, so it never jumps mid-transfer.
   // Without wrap, the end parks reading
   // until software clears RDEN or moves the pointer.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ptr_ff <= 16'h0;
         stopped_ff <= 1'b0;
      end else if (ptr_wr && !rden_ff) begin
         ptr_ff <= wdata_ff[15:0];
         stopped_ff <= 1'b0;
      end else if (take) begin
         if (at_end) begin
            ptr_ff <= 16'h0;
            stopped_ff <= !auto_ff;
         end else begin
            ptr_ff <= ptr_next[15:0];
         end
      end else if (ctrl_wr && wstrb_ff[0] && !wdata_ff[mcrd_pkg::B_RDEN]) begin
         stopped_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Code FIFO and guest writes
   // ----------------------------------------------------------------
   // Flush holds the FIFO pointers together, so only a word
   // already taken by the write engine still reaches the guest.
   mcrd_fifo #(.DEPTH_LOG2(FIFO_LOG2)) u_fifo (
      .clk(CORE_CLK),
      .rst(RST),
      .flush(flush_ff),
      .in_valid(take),
      .in_ready(fifo_in_ready),
      .in_data(HOST_RD_DATA),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   mcrd_guest_wr #(.TIMEOUT(mcrd_pkg::TIMEOUT_CLKS)) u_gw (
      .clk(CORE_CLK),
      .rst(RST),
      .in_valid(fifo_out_valid),
      .in_ready(fifo_out_ready),
      .in_data(fifo_out_data),
      .gw_req(GUEST_WR_REQ),
      .gw_data(GUEST_WR_DATA),
      .gw_done(GUEST_WR_DONE),
      .timeout_pulse(timeout_pulse)
   );


   // A select change applies at once, even to
   // a code-write cycle already in progress.
   assign GUEST_SEL = guest_ff;
   assign GUEST_REG = greg_ff;
endmodule // mcrd_ctrl
`default_nettype wire

// ### test/mcrd_ctrl_props.sv
// Concurrent checks on the code-read DMA control block ports.
`timescale 1ns/1ps
`default_nettype none
module mcrd_ctrl_props #(
   parameter int FIFO_LOG2 = 3
) (
   // Clock and reset.
   input wire logic CORE_CLK,
   input wire logic RST,
   // Register bus.
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic [31:0] RDATA,
   // Host and guest ports.
   input wire logic HOST_RD_REQ,
   input wire logic [31:0] HOST_RD_ADDR,
   input wire logic HOST_RD_VALID,
   input wire logic GUEST_WR_REQ,
   input wire logic [31:0] GUEST_WR_DATA,
   input wire logic GUEST_WR_DONE
);
   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RST);
   sequence s_aw_w;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence s_take;
      HOST_RD_REQ && HOST_RD_VALID;
   endsequence
   sequence s_gw_end;
      GUEST_WR_REQ && GUEST_WR_DONE;
   endsequence
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   chk_b_follows: assert property (s_aw_w |-> ##2 BVALID)
      else $error("Write response did not follow the write.");
   chk_b_holds: assert property (BVALID && !BREADY |=> BVALID)
      else $error("Write response dropped early.");
   chk_r_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("Read response changed before it was taken.");
   chk_ar_ready: assert property (ARVALID && ARREADY |=> RVALID ##0 !ARREADY)
      else $error("Read answer or address refusal wrong.");
   chk_addr_align: assert property (HOST_RD_REQ |-> HOST_RD_ADDR[1:0] == 2'h0)
      else $error("Host read address not DWORD aligned.");
   // Register writes may move the pointer, so bus activity is excluded.
   chk_ptr_hold: assert property (!HOST_RD_VALID && !$past(AWVALID) && !$past(WVALID)
      && !AWVALID && !WVALID && !BVALID
      |=> $stable(HOST_RD_ADDR))
      else $error("Pointer moved without a host read.");
   chk_ptr_moves: assert property (s_take |=> HOST_RD_ADDR != $past(HOST_RD_ADDR))
      else $error("Pointer did not advance after a host read.");
   chk_guest_end: assert property (s_gw_end |=> !GUEST_WR_REQ)
      else $error("Guest write did not end after done.");
   chk_guest_hold: assert property (GUEST_WR_REQ && !GUEST_WR_DONE
      |=> GUEST_WR_REQ && $stable(GUEST_WR_DATA))
      else $error("Guest write changed before done.");
endmodule // mcrd_ctrl_props
bind mcrd_ctrl mcrd_ctrl_props #(.FIFO_LOG2(FIFO_LOG2)) u_props (
   .CORE_CLK(CORE_CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
   .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
   .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
   .RDATA(RDATA), .HOST_RD_REQ(HOST_RD_REQ), .HOST_RD_ADDR(HOST_RD_ADDR),
   .HOST_RD_VALID(HOST_RD_VALID), .GUEST_WR_REQ(GUEST_WR_REQ),
   .GUEST_WR_DATA(GUEST_WR_DATA), .GUEST_WR_DONE(GUEST_WR_DONE));
`default_nettype wire

// ### test/mcrd_guest_model.sv
// Guest peripheral model that ends each code-write after a set delay.
`timescale 1ns/1ps
`default_nettype none
module mcrd_guest_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Guest bus.
   input wire logic req,
   input wire logic [2:0] gsel,
   input wire logic [2:0] greg,
   input wire logic [31:0] data,
   output logic done,
   // Cycles the guest stalls each write.
   input wire logic [7:0] delay
);
   logic [7:0] cnt_ff;
   logic [37:0] got[$];
   // A long delay keeps the strobe low and forces a timeout.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         done <= 1'b0;
         cnt_ff <= 8'h00;
      end else if (done) begin
         done <= 1'b0;
         cnt_ff <= 8'h00;
      end else if (req) begin
         if (cnt_ff + 8'h01 >= delay) begin
            done <= 1'b1;
            got.push_back({gsel, greg, data});
         end else begin
            cnt_ff <= cnt_ff + 8'h01;
         end
      end
   end
endmodule // mcrd_guest_model
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench for the code-read DMA control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic CORE_CLK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0;
   logic RREADY = 0, HOST_RD_VALID = 0, GUEST_WR_DONE, tk;
   logic [7:0] AWADDR = 0, ARADDR = 0, gdly = 1;
   logic [3:0] WSTRB = 0;
   logic [31:0] WDATA = 0, HOST_RD_DATA = 32'hC0DE0000, RDATA, HOST_RD_ADDR, GUEST_WR_DATA;
   logic [31:0] base_v = 32'h00001000, eptr = 0, size_dw = 2048, tad;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, HOST_RD_REQ, GUEST_WR_REQ;
   logic [1:0] BRESP, RRESP;
   logic [2:0] GUEST_SEL, GUEST_REG;
   int num_errors = 0, samples_checked = 0, takes = 0;
   always #2.5 CORE_CLK = ~CORE_CLK;
   mcrd_ctrl dut (.CORE_CLK(CORE_CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
      .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
      .HOST_RD_REQ(HOST_RD_REQ), .HOST_RD_ADDR(HOST_RD_ADDR), .HOST_RD_VALID(HOST_RD_VALID),
      .HOST_RD_DATA(HOST_RD_DATA), .GUEST_WR_REQ(GUEST_WR_REQ), .GUEST_SEL(GUEST_SEL),
      .GUEST_REG(GUEST_REG), .GUEST_WR_DATA(GUEST_WR_DATA), .GUEST_WR_DONE(GUEST_WR_DONE));
   mcrd_guest_model gm (.clk(CORE_CLK), .rst(RST), .req(GUEST_WR_REQ), .gsel(GUEST_SEL),
      .greg(GUEST_REG), .data(GUEST_WR_DATA), .done(GUEST_WR_DONE), .delay(gdly));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [37:0] g, input logic [37:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge CORE_CLK);
   endtask
   // Host memory: valid toggles, and data is scrambled while not valid.
   always @(negedge CORE_CLK) begin
      tk = HOST_RD_REQ === 1'b1 && HOST_RD_VALID === 1'b1;
      tad = HOST_RD_ADDR;
   end
   always @(posedge CORE_CLK) begin
      HOST_RD_VALID <= ~HOST_RD_VALID;
      if (tk) begin
         chk(tad, base_v + {eptr[29:0], 2'b00}, "host address");
         takes++;
         eptr = (eptr + 1) % size_dw;
      end
      HOST_RD_DATA <= HOST_RD_VALID ? ~HOST_RD_DATA : 32'hC0DE0000 + takes;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = mcrd_pkg::RESP_OKAY);
      logic ao, wo, bo;
      logic [1:0] r;
      int n;
      @(posedge CORE_CLK);
      AWVALID <= 1; AWADDR <= a; WVALID <= 1; WDATA <= d; WSTRB <= 4'hF; BREADY <= 1;
      for (n = 0; n < 50; n++) begin
         @(negedge CORE_CLK);
         ao = AWVALID && AWREADY === 1'b1;
         wo = WVALID && WREADY === 1'b1;
         bo = BVALID === 1'b1;
         r = BRESP;
         @(posedge CORE_CLK);
         if (ao) AWVALID <= 0;
         if (wo) WVALID <= 0;
         if (bo) break;
      end
      BREADY <= 0;
      chk({n < 50, r}, {1'b1, er}, "write response");
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = mcrd_pkg::RESP_OKAY);
      logic ao, ro;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      @(posedge CORE_CLK);
      ARVALID <= 1; ARADDR <= a; RREADY <= 1;
      for (n = 0; n < 50; n++) begin
         @(negedge CORE_CLK);
         ao = ARVALID && ARREADY === 1'b1;
         ro = RVALID === 1'b1;
         d = RDATA;
         r = RRESP;
         @(posedge CORE_CLK);
         if (ao) ARVALID <= 0;
         if (ro) break;
      end
      RREADY <= 0;
      chk({n < 50, r, d}, {1'b1, er, e}, "read response");
   endtask
   task automatic wgot(input int k);
      for (int n = 0; n < 2000 && gm.got.size() < k; n++) tick(1);
      chk(gm.got.size() >= k, 1, "guest words");
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   task automatic t_reset();
      rdc(mcrd_pkg::ADDR_CTRL, 32'h3000310C);
      rdc(mcrd_pkg::ADDR_BASE, 32'hFFFFFFFC);
      rdc(mcrd_pkg::ADDR_PTR, 32'h0);
      rdc(mcrd_pkg::ADDR_STAT, 32'h0);
      rdc(8'h00, 32'h0, mcrd_pkg::RESP_SLVERR);
      wr(8'h40, 32'h1, mcrd_pkg::RESP_SLVERR);
      wr(mcrd_pkg::ADDR_BASE, 32'h00001003);
      rdc(mcrd_pkg::ADDR_BASE, 32'h00001000);
      $display("Test reset done");
   endtask
   task automatic t_stream();
      wr(mcrd_pkg::ADDR_CTRL, 32'h0052008D);
      wgot(20);
      wr(mcrd_pkg::ADDR_CTRL, 32'h0052000D);
      rdc(mcrd_pkg::ADDR_PTR, eptr);
      tick(20);
      rdc(mcrd_pkg::ADDR_PTR, eptr);
      wr(mcrd_pkg::ADDR_CTRL, 32'h0052008D);
      wgot(40);
      wr(mcrd_pkg::ADDR_CTRL, 32'h0052000D);
      tick(40);
      chk(gm.got.size(), takes, "words forwarded");
      rdc(mcrd_pkg::ADDR_CTRL, 32'h2052000D);
      foreach (gm.got[i]) chk(gm.got[i], {6'o52, 32'(32'hC0DE0000 + i)}, "word");
      $display("Test stream done");
   endtask
   task automatic t_timeout();
      int c;
      gdly <= 100;
      c = takes;
      wr(mcrd_pkg::ADDR_CTRL, 32'h00000085);
      tick(90);
      chk(takes - c, 3, "refill stop");
      rdc(mcrd_pkg::ADDR_CTRL, 32'h40000085);
      wr(mcrd_pkg::ADDR_CTRL, 32'h50000004);
      rdc(mcrd_pkg::ADDR_CTRL, 32'h30000004);
      gdly <= 1;
      tick(10);
      $display("Test timeout done");
   endtask
   task automatic t_end();
      logic [2:0] cs [6] = '{0, 1, 5, 6, 7, 0};
      logic au;
      int c;
      foreach (cs[k]) begin
         au = k == 5;
         size_dw = cs[k] > 5 ? 16384 : 2048 << cs[k];
         wr(mcrd_pkg::ADDR_CTRL, {17'h0, cs[k], 11'h006, au});
         wr(mcrd_pkg::ADDR_PTR, size_dw - 2);
         eptr = size_dw - 2;
         wr(mcrd_pkg::ADDR_STAT, 32'h10000000);
         c = takes;
         wr(mcrd_pkg::ADDR_CTRL, {17'h0, cs[k], 11'h046, au});
         tick(40);
         wr(mcrd_pkg::ADDR_CTRL, {17'h0, cs[k], 11'h006, au});
         chk(au ? takes - c > 2 : takes - c == 2, 1, "end of buffer");
         rdc(mcrd_pkg::ADDR_PTR, eptr);
         rdc(mcrd_pkg::ADDR_STAT, 32'h10000000);
         wr(mcrd_pkg::ADDR_STAT, 32'h10000000);
         rdc(mcrd_pkg::ADDR_STAT, 32'h0);
      end
      $display("Test end of buffer done");
   endtask
   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      tick(4);
      RST <= 0;
      t_reset();
      t_stream();
      t_timeout();
      t_end();
      complete_run();
   end
   initial begin
      tick(30000);
      num_errors++;
      complete_run();
   end
endmodule // tb
`default_nettype wire
